// ==== core/acs_defines.svh ====
/*
 * offsets, field positions, reset values and timing counts of the
 * conversion sequencer; assumes a 40 MHz system clock
 */
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// register byte addresses
`define ACS_OFS_CTL0     8'h00
`define ACS_OFS_CTL1     8'h04
`define ACS_OFS_CTL2     8'h08
`define ACS_OFS_RES_HI   8'h0c
`define ACS_OFS_RES_LO   8'h10
`define ACS_OFS_STAT     8'h14
// control zero fields
`define ACS_ON_BIT       0
`define ACS_GO_BIT       1
`define ACS_CHS_LSB      2
// control one fields
`define ACS_JUST_BIT     7
`define ACS_CKS_LSB      4
// status fields
`define ACS_FLAG_BIT     0
`define ACS_IEN_BIT      1
`define ACS_PWR_BIT      2
// reset values
`define ACS_CTL_RST      8'h00
// channel codes
`define ACS_CH_AN_MAX    5'h04
`define ACS_CH_VREFP     5'h1a
`define ACS_CH_TEMP      5'h1d
`define ACS_CH_FIXREF    5'h1f
// axi responses
`define ACS_RESP_OKAY    2'h0
`define ACS_RESP_SLVERR  2'h2
// one instruction cycle of extra start delay on the rc clock
`define ACS_CLK_MHZ      40
`define ACS_INSTR_NS     100
`define ACS_INSTR_CLKS   ((`ACS_INSTR_NS*`ACS_CLK_MHZ+999)/1000)
`endif

// ==== core/acs_pkg.sv ====
/*
 * types of the conversion sequencer; no assumptions beyond the header
 */
package acs_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_DELAY  = 2'b01,
      ST_SAMPLE = 2'b10,
      ST_CONV   = 2'b11
   } acs_state_t;
   // drive toward the analog core
   typedef struct packed {
      logic       power;
      logic       hold;
      logic [9:0] trial;
      logic [4:0] channel;
      logic       chan_valid;
      logic [1:0] vref_sel;
   } acs_core_t;
endpackage

// ==== core/acs_sequencer.sv ====
/*
 * axi4-lite register file and successive-approximation sequencer of a
 * 10-bit converter. assumes a synchronous comparator input, a one-cycle
 * rc tick pulse, a one-cycle timer overflow pulse and a sleep level,
 * all synchronous to aclk.
 */
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defines.svh"

module acs_sequencer (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [7:0]        s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   // axi4-lite read
   input  wire logic [7:0]        s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   // analog core and system events
   input  wire logic              cmp_high,
   input  wire logic              rc_tick,
   input  wire logic              timer_zero_ovf,
   input  wire logic              sleep_in,
   output acs_pkg::acs_core_t     core,
   output logic                   conv_irq,
   output logic                   wake_req
);

   ////////////////////////////////////////////////////////////////////
   // state
   logic                 aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
   logic [7:0]           aw_addr_ff;
   logic [7:0]           w_data_ff;
   logic                 w_strb_ff;
   logic [31:0]          rdata_ff;
   logic [1:0]           bresp_ff, rresp_ff;
   logic                 on_ff, just_ff, trig_ff, flag_ff, ien_ff;
   logic [4:0]           chan_ff;
   logic [2:0]           cks_ff;
   logic [1:0]           vref_ff;
   logic [7:0]           res_hi_ff, res_lo_ff;
   logic [9:0]           sar_ff;
   logic [3:0]           idx_ff;
   logic [2:0]           dly_ff;
   logic [5:0]           div_ff;
   logic                 slp_off_ff, irq_ff, wake_ff;
   acs_pkg::acs_state_t  st_ff, nxt_st;
   acs_pkg::acs_core_t   core_ff, nxt_core;

   // every check below samples on aclk and rests while reset is held
   default clocking chk_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////
   // bus decode: write fires once address and data are both held
   wire       wr_fire  = aw_full_ff & w_full_ff & ~bvalid_ff;
   wire       wr_en    = wr_fire & w_strb_ff;
   wire       wr_ctl0  = wr_en & (aw_addr_ff == `ACS_OFS_CTL0);
   wire       wr_ctl1  = wr_en & (aw_addr_ff == `ACS_OFS_CTL1);
   wire       wr_ctl2  = wr_en & (aw_addr_ff == `ACS_OFS_CTL2);
   wire       wr_stat  = wr_en & (aw_addr_ff == `ACS_OFS_STAT);
   wire       wr_map   = (aw_addr_ff == `ACS_OFS_CTL0) |
                         (aw_addr_ff == `ACS_OFS_CTL1) |
                         (aw_addr_ff == `ACS_OFS_CTL2) |
                         (aw_addr_ff == `ACS_OFS_RES_HI) |
                         (aw_addr_ff == `ACS_OFS_RES_LO) |
                         (aw_addr_ff == `ACS_OFS_STAT);
   wire       rd_fire  = s_arvalid & s_arready;
   wire       busy     = (st_ff != acs_pkg::ST_IDLE);

   ////////////////////////////////////////////////////////////////////
   // clock source and conversion clock tick
   wire       is_rc    = (cks_ff[1:0] == 2'b11);
   wire [2:0] div_log  = {cks_ff[1:0], cks_ff[2]} + 3'h1;
   wire [5:0] div_mask = 6'((7'h01 << div_log) - 7'h01);
   wire       sys_tick = ((div_ff & div_mask) == div_mask);
   wire       tad      = is_rc ? rc_tick : sys_tick;

   ////////////////////////////////////////////////////////////////////
   // starts, aborts and completion
   wire sw_start   = wr_ctl0 & w_data_ff[`ACS_GO_BIT] &
                     w_data_ff[`ACS_ON_BIT] & ~busy;
   wire hw_start   = trig_ff & timer_zero_ovf & on_ff & ~busy &
                     ~wr_ctl0;
   wire start      = sw_start | hw_start;
   wire sw_abort   = wr_ctl0 & ~w_data_ff[`ACS_GO_BIT] & busy;
   // a system-clock conversion cannot survive sleep
   wire slp_abort  = sleep_in & ~is_rc & busy;
   wire off_abort  = wr_ctl0 & ~w_data_ff[`ACS_ON_BIT] & busy;
   wire stop       = sw_abort | slp_abort | off_abort;
   wire last_bit   = (st_ff == acs_pkg::ST_CONV) & tad &
                     (idx_ff == 4'h0);
   wire done       = last_bit & ~stop;
   wire resolved   = (st_ff == acs_pkg::ST_CONV) & (idx_ff != 4'h9);

   ////////////////////////////////////////////////////////////////////
   // result: final word, or partial word with fill of last bit
   logic [9:0] part_res;
   logic [9:0] final_res;
   wire        fill = resolved ? sar_ff[idx_ff + 4'h1] : 1'b0;
   genvar gi;
   generate
      for (gi = 0; gi < 10; gi = gi + 1)
      begin : g_part
         assign part_res[gi]  = (4'(gi) > idx_ff) ? sar_ff[gi]
                                                  : fill;
         assign final_res[gi] = (4'(gi) == 4'h0) ? cmp_high
                                                 : sar_ff[gi];
      end
   endgenerate
   wire [9:0] load_val = done ? final_res : part_res;
   wire       load     = done | (sw_abort & ~slp_abort);
   wire [7:0] nxt_hi   = just_ff ? {6'h00, load_val[9:8]}
                                 : load_val[9:2];
   wire [7:0] nxt_lo   = just_ff ? load_val[7:0]
                                 : {load_val[1:0], 6'h00};

   ////////////////////////////////////////////////////////////////////
   // flags and power
   wire clr_flag  = wr_stat & w_data_ff[`ACS_FLAG_BIT];
   wire nxt_flag  = done | (flag_ff & ~clr_flag);
   wire nxt_ien   = wr_stat ? w_data_ff[`ACS_IEN_BIT] : ien_ff;
   wire nxt_on    = wr_ctl0 ? w_data_ff[`ACS_ON_BIT] : on_ff;
   // sleep power-off keeps converter_on set; cleared on wake
   wire nxt_soff  = sleep_in & (slp_off_ff | ~is_rc |
                    (done & ~ien_ff));
   wire chan_ok   = (chan_ff <= `ACS_CH_AN_MAX) |
                    (chan_ff == `ACS_CH_VREFP) |
                    (chan_ff == `ACS_CH_TEMP) |
                    (chan_ff == `ACS_CH_FIXREF);

   ////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff)
         acs_pkg::ST_IDLE:
            if (start)
               nxt_st = is_rc ? acs_pkg::ST_DELAY
                              : acs_pkg::ST_SAMPLE;
         acs_pkg::ST_DELAY:
            if (stop)
               nxt_st = acs_pkg::ST_IDLE;
            else if (dly_ff == 3'(`ACS_INSTR_CLKS - 1))
               nxt_st = acs_pkg::ST_SAMPLE;
         acs_pkg::ST_SAMPLE:
            if (stop)
               nxt_st = acs_pkg::ST_IDLE;
            else if (tad)
               nxt_st = acs_pkg::ST_CONV;
         acs_pkg::ST_CONV:
            if (stop | last_bit)
               nxt_st = acs_pkg::ST_IDLE;
         default:
            nxt_st = acs_pkg::ST_IDLE;
      endcase
   end

   // analog drive, registered so every core pin comes from a flop
   always_comb
   begin
      nxt_core            = core_ff;
      nxt_core.power      = nxt_on & ~nxt_soff;
      nxt_core.hold       = (nxt_st == acs_pkg::ST_CONV);
      nxt_core.channel    = chan_ff;
      nxt_core.chan_valid = chan_ok;
      nxt_core.vref_sel   = vref_ff;
      nxt_core.trial      = 10'h000;
      if (nxt_st == acs_pkg::ST_CONV)
      begin
         if (st_ff == acs_pkg::ST_CONV)
            nxt_core.trial = (sar_ff | (10'h001 << (idx_ff - 4'h1)));
         else
            nxt_core.trial = 10'h200;
         if (st_ff == acs_pkg::ST_CONV && !tad)
            nxt_core.trial = core_ff.trial;
         else if (st_ff == acs_pkg::ST_CONV)
            nxt_core.trial[idx_ff] = cmp_high;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_ff  <= acs_pkg::ST_IDLE;
         sar_ff <= 10'h000;
         idx_ff <= 4'h9;
         dly_ff <= 3'h0;
         div_ff <= 6'h00;
      end
      else
      begin
         st_ff  <= nxt_st;
         div_ff <= div_ff + 6'h01;
         dly_ff <= (st_ff == acs_pkg::ST_DELAY) ? dly_ff + 3'h1 : 3'h0;
         if (start)
         begin
            sar_ff <= 10'h000;
            idx_ff <= 4'h9;
         end
         else if ((st_ff == acs_pkg::ST_CONV) && tad)
         begin
            sar_ff[idx_ff] <= cmp_high;
            idx_ff         <= idx_ff - 4'h1;
         end
      end
   end

   // control, status and result registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         on_ff      <= 1'b0;
         chan_ff    <= 5'h00;
         just_ff    <= 1'b0;
         cks_ff     <= 3'h0;
         vref_ff    <= 2'h0;
         trig_ff    <= 1'b0;
         flag_ff    <= 1'b0;
         ien_ff     <= 1'b0;
         res_hi_ff  <= 8'h00;
         res_lo_ff  <= 8'h00;
         slp_off_ff <= 1'b0;
         irq_ff     <= 1'b0;
         wake_ff    <= 1'b0;
         core_ff    <= '0;
      end
      else
      begin
         on_ff      <= nxt_on;
         flag_ff    <= nxt_flag;
         ien_ff     <= nxt_ien;
         slp_off_ff <= nxt_soff;
         core_ff    <= nxt_core;
         irq_ff     <= nxt_flag & nxt_ien;
         wake_ff    <= nxt_flag & nxt_ien & sleep_in;
         if (wr_ctl0)
            chan_ff <= w_data_ff[6:2];
         if (wr_ctl1)
         begin
            just_ff <= w_data_ff[`ACS_JUST_BIT];
            cks_ff  <= w_data_ff[6:4];
            vref_ff <= w_data_ff[1:0];
         end
         if (wr_ctl2)
            trig_ff <= w_data_ff[0];
         if (load)
         begin
            res_hi_ff <= nxt_hi;
            res_lo_ff <= nxt_lo;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux; go bit mirrors the busy sequencer
   logic [7:0] rd_byte;
   wire  [7:0] ctl0_rd = {1'b0, chan_ff, busy, on_ff};
   wire  [7:0] ctl1_rd = {just_ff, cks_ff, 2'b00, vref_ff};
   wire  [7:0] stat_rd = {5'h00, core_ff.power, ien_ff, flag_ff};
   wire        rd_map  = (s_araddr == `ACS_OFS_CTL0) |
                         (s_araddr == `ACS_OFS_CTL1) |
                         (s_araddr == `ACS_OFS_CTL2) |
                         (s_araddr == `ACS_OFS_RES_HI) |
                         (s_araddr == `ACS_OFS_RES_LO) |
                         (s_araddr == `ACS_OFS_STAT);
   always_comb
   begin
      case (s_araddr)
         `ACS_OFS_CTL0:   rd_byte = ctl0_rd;
         `ACS_OFS_CTL1:   rd_byte = ctl1_rd;
         `ACS_OFS_CTL2:   rd_byte = {7'h00, trig_ff};
         `ACS_OFS_RES_HI: rd_byte = res_hi_ff;
         `ACS_OFS_RES_LO: rd_byte = res_lo_ff;
         `ACS_OFS_STAT:   rd_byte = stat_rd;
         default:         rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // axi4-lite handshakes: one write and one read in flight at most
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_ff <= 1'b0;
         w_full_ff  <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff  <= 8'h00;
         w_strb_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `ACS_RESP_OKAY;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `ACS_RESP_OKAY;
      end
      else
      begin
         if (s_awvalid && s_awready)
         begin
            aw_full_ff <= 1'b1;
            aw_addr_ff <= s_awaddr;
         end
         else if (wr_fire)
            aw_full_ff <= 1'b0;
         if (s_wvalid && s_wready)
         begin
            w_full_ff <= 1'b1;
            w_data_ff <= s_wdata[7:0];
            w_strb_ff <= s_wstrb[0];
         end
         else if (wr_fire)
            w_full_ff <= 1'b0;
         if (wr_fire)
         begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_map ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
         end
         else if (s_bready)
            bvalid_ff <= 1'b0;
         if (rd_fire)
         begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h000000, rd_byte};
            rresp_ff  <= rd_map ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
         end
         else if (s_rready)
            rvalid_ff <= 1'b0;
      end
   end

   // readies are flops: low while the slot is held or an answer waits
   logic awready_ff, wready_ff, arready_ff;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         arready_ff <= 1'b0;
      end
      else
      begin
         awready_ff <= ~(s_awvalid & s_awready) & ~aw_full_ff &
                       ~bvalid_ff & ~wr_fire;
         wready_ff  <= ~(s_wvalid & s_wready) & ~w_full_ff &
                       ~bvalid_ff & ~wr_fire;
         arready_ff <= ~rd_fire & ~rvalid_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign s_awready = awready_ff;
   assign s_wready  = wready_ff;
   assign s_bvalid  = bvalid_ff;
   assign s_bresp   = bresp_ff;
   assign s_arready = arready_ff;
   assign s_rvalid  = rvalid_ff;
   assign s_rdata   = rdata_ff;
   assign s_rresp   = rresp_ff;
   assign core      = core_ff;
   assign conv_irq  = irq_ff;
   assign wake_req  = wake_ff;

   ////////////////////////////////////////////////////////////////////
   // checks; clock and reset come from the defaults at the top
   a_done_sets_flag: assert property (done |=> flag_ff)
      else $error("flag not set on completion");
   a_flag_holds: assert property (flag_ff && !clr_flag |=> flag_ff)
      else $error("flag dropped without clear");
   a_irq_follows: assert property (flag_ff && ien_ff |-> conv_irq)
      else $error("irq missing with flag and enable");
   a_rc_delay_wait: assert property (
      start && is_rc |=> (st_ff == acs_pkg::ST_DELAY) [*3])
      else $error("rc start not delayed");
   a_go_clears: assert property (
      done |=> !busy ##0 res_hi_ff == $past(nxt_hi))
      else $error("completion did not idle and load");
   a_sleep_abort: assert property (
      slp_abort |=> !busy ##1 !core_ff.power && on_ff == $past(on_ff, 2))
      else $error("sleep abort did not power off");
   // power follows converter_on in the same cycle, so a turn-on write
   // must not be taken for a powered-while-off fault
   a_off_unpowered: assert property (!on_ff |-> !core_ff.power)
      else $error("powered while converter off");
   a_bit7_zero: assert property (
      rd_fire && s_araddr == `ACS_OFS_CTL0 |=> !s_rdata[7])
      else $error("control bit seven read nonzero");
   a_result_holds: assert property (
      !load |=> $stable(res_hi_ff) && $stable(res_lo_ff))
      else $error("result changed without load");

endmodule // acs_sequencer
`default_nettype wire

// ==== verification/acs_core_model.sv ====
/* behavioural analog core: comparator against a level set by the channel,
   and a free-running rc tick. assumes the core struct of acs_pkg */
`timescale 1ns/100ps
`default_nettype none
module acs_core_model (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // core side
   input  wire acs_pkg::acs_core_t core,
   output logic              cmp_high,
   output logic              rc_tick
);
   logic [2:0] tick_cnt_ff;
   logic       toggle_ff;
   logic [9:0] level;
   // input level equals the code, so the >= compare resolves to exactly that code
   assign level = {core.channel, core.channel};
   // unpowered or unconnected input gives a pattern, not a stale level
   assign cmp_high = (core.power && core.chan_valid) ?
                     (level >= core.trial) : toggle_ff;
   // rc tick once every eight cycles
   always_ff @(posedge aclk)
   begin
      tick_cnt_ff <= aresetn ? tick_cnt_ff + 3'h1 : 3'h0;
      toggle_ff   <= ~toggle_ff & aresetn;
      rc_tick     <= aresetn && (tick_cnt_ff == 3'h7);
   end
endmodule // acs_core_model
`default_nettype wire

// ==== verification/test_acs_sequencer.sv ====
/* register-level scenarios for the conversion sequencer over axi4-lite.
   assumes acs_core_model on the analog side and a 40 MHz aclk */
`timescale 1ns/100ps
`default_nettype none
`include "acs_defines.svh"
module test_acs_sequencer;
   logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0, s_rdata, rd;
   logic [3:0]  s_wstrb = 4'h1;
   logic [1:0]  s_bresp, s_rresp, rsp;
   logic        aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0;
   logic        s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
   logic        s_rready = 1'b0, timer_zero_ovf = 1'b0, sleep_in = 1'b0;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic        cmp_high, rc_tick, conv_irq, wake_req;
   acs_pkg::acs_core_t core;
   int          miscompares = 0, checked = 0;
   always #12.5 aclk = ~aclk;
   acs_sequencer uut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
      .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
      .s_rvalid, .s_rready, .cmp_high, .rc_tick, .timer_zero_ovf,
      .sleep_in, .core, .conv_irq, .wake_req);
   acs_core_model model (.aclk, .aresetn, .core, .cmp_high, .rc_tick);
   ////////////////////////////////////////
   // ends the run; also reached by the watchdog
   task automatic give_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // readies are looked at on the falling edge, where they are settled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_hit, w_hit, b_hit;
      @(posedge aclk);
      s_awaddr  <= a;
      s_wdata   <= {24'h000000, d};
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      do
      begin
         @(negedge aclk);
         aw_hit = s_awvalid & s_awready;
         w_hit  = s_wvalid & s_wready;
         b_hit  = s_bready & s_bvalid;
         rsp    = s_bresp;
         @(posedge aclk);
         if (aw_hit) s_awvalid <= 1'b0;
         if (w_hit) s_wvalid <= 1'b0;
         if (b_hit) s_bready <= 1'b0;
      end
      while (!b_hit);
   endtask
   task automatic rdr(input logic [7:0] a);
      logic ar_hit, r_hit;
      @(posedge aclk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      do
      begin
         @(negedge aclk);
         ar_hit = s_arvalid & s_arready;
         r_hit  = s_rready & s_rvalid;
         rd     = s_rdata;
         rsp    = s_rresp;
         @(posedge aclk);
         if (ar_hit) s_arvalid <= 1'b0;
         if (r_hit) s_rready <= 1'b0;
      end
      while (!r_hit);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      rdr(a);
      chk(rd, {24'h000000, exp});
   endtask
   task automatic rst;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask
   // enable first, wait for acquisition, then start in a later write
   task automatic start(input logic [4:0] ch);
      wr(`ACS_OFS_CTL0, {1'b0, ch, 2'b01});
      repeat (20) @(posedge aclk);
      wr(`ACS_OFS_CTL0, {1'b0, ch, 2'b11});
      rdr(`ACS_OFS_CTL0);
      chk(rd & 32'h2, 32'h2);
   endtask
   task automatic wait_idle;
      do rdr(`ACS_OFS_CTL0); while (rd[1] !== 1'b0);
   endtask
   // expected layout of the level that the core model presents
   task automatic res_chk(input logic [4:0] ch, input logic j);
      logic [9:0] v;
      v = {ch, ch};
      chk_rd(`ACS_OFS_RES_HI, j ? {6'h00, v[9:8]} : v[9:2]);
      chk_rd(`ACS_OFS_RES_LO, j ? v[7:0] : {v[1:0], 6'h00});
   endtask
   // partial result: a resolved prefix, the rest copies its last bit
   function automatic logic part_ok(input logic [9:0] v, input logic [9:0] r);
      logic [9:0] m;
      part_ok = 1'b0;
      for (int k = 1; k < 10; k++)
      begin
         m = (10'h001 << k) - 10'h001;
         if ((r >> k) == (v >> k) && (r & m) == (r[k] ? m : 10'h000))
            part_ok = 1'b1;
      end
   endfunction
   ////////////////////////////////////////
   // hang guard, well beyond the expected run
   initial
   begin
      repeat (60000) @(posedge aclk);
      miscompares++;
      give_verdict;
   end
   // main sequence
   initial
   begin
      logic [4:0] ch;
      logic [9:0] r;
      rst;
      for (int i = 0; i < 3; i++) chk_rd(8'(i * 4), 8'h00);
      chk_rd(`ACS_OFS_STAT, 8'h00);
      rdr(8'h18);
      chk(32'(rsp), 32'(`ACS_RESP_SLVERR));
      chk(rd, 32'h0);
      wr(8'h18, 8'hff);
      chk(32'(rsp), 32'(`ACS_RESP_SLVERR));
      wr(`ACS_OFS_CTL0, 8'h80);
      chk_rd(`ACS_OFS_CTL0, 8'h00);
      // control one reads back with bits 3:2 at zero; vref reaches the core
      wr(`ACS_OFS_CTL1, 8'hff);
      chk_rd(`ACS_OFS_CTL1, 8'hf3);
      chk(32'(core.vref_sel), 32'h3);
      // one mask bit per connected channel code: 0 to 4, 26, 29, 31
      for (int c = 0; c < 32; c++)
      begin
         wr(`ACS_OFS_CTL0, 8'(c << 2));
         @(negedge aclk);
         chk(32'(core.chan_valid), (32'ha400_001f >> c) & 32'h1);
      end
      // every clock code, both layouts
      for (int c = 0; c < 8; c++)
      begin
         ch = (c < 5) ? 5'(c) : 5'h1f;
         wr(`ACS_OFS_CTL1, {c[0], c[2:0], 4'h0});
         start(ch);
         wait_idle;
         chk_rd(`ACS_OFS_CTL0, {1'b0, ch, 2'b01});
         res_chk(ch, c[0]);
         chk_rd(`ACS_OFS_STAT, 8'h05);
         wr(`ACS_OFS_STAT, 8'h01);
         chk_rd(`ACS_OFS_STAT, 8'h04);
         res_chk(ch, c[0]);
      end
      // sleep on the rc clock, interrupt off then on
      for (int ie = 0; ie < 2; ie++)
      begin
         wr(`ACS_OFS_STAT, 8'(ie * 2));
         wr(`ACS_OFS_CTL1, 8'h30);
         start(5'h02);
         @(posedge aclk);
         sleep_in <= 1'b1;
         wait_idle;
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         chk(32'(conv_irq), 32'(ie));
         chk(32'(wake_req), 32'(ie));
         chk(32'(core.power), 32'(ie));
         chk_rd(`ACS_OFS_CTL0, 8'h09);
         res_chk(5'h02, 1'b0);
         @(posedge aclk);
         sleep_in <= 1'b0;
         wr(`ACS_OFS_STAT, 8'h01);
      end
      // sleep on a system clock code aborts
      wr(`ACS_OFS_CTL1, 8'he0);
      start(5'h04);
      @(posedge aclk);
      sleep_in <= 1'b1;
      repeat (10) @(posedge aclk);
      @(negedge aclk);
      chk(32'(core.power), 32'h0);
      chk_rd(`ACS_OFS_CTL0, 8'h11);
      @(posedge aclk);
      sleep_in <= 1'b0;
      // software abort part-way through
      start(5'h04);
      repeat (300) @(posedge aclk);
      @(negedge aclk);
      chk(32'(core.hold), 32'h1);
      wr(`ACS_OFS_CTL0, 8'h11);
      @(negedge aclk);
      chk(32'(core.hold), 32'h0);
      rdr(`ACS_OFS_RES_HI);
      r[9:8] = rd[1:0];
      rdr(`ACS_OFS_RES_LO);
      r[7:0] = rd[7:0];
      chk(32'(part_ok(10'h084, r)), 32'h1);
      // timer overflow start
      wr(`ACS_OFS_CTL2, 8'h01);
      wr(`ACS_OFS_CTL1, 8'h80);
      wr(`ACS_OFS_CTL0, 8'h0d);
      repeat (20) @(posedge aclk);
      timer_zero_ovf <= 1'b1;
      @(posedge aclk);
      timer_zero_ovf <= 1'b0;
      chk_rd(`ACS_OFS_CTL0, 8'h0f);
      wait_idle;
      res_chk(5'h03, 1'b1);
      wr(`ACS_OFS_CTL2, 8'h00);
      wr(`ACS_OFS_CTL0, 8'h00);
      @(negedge aclk);
      chk(32'(core.power), 32'h0);
      chk_rd(`ACS_OFS_STAT, 8'h01);
      // clearing converter_on mid-conversion stops it without a load
      wr(`ACS_OFS_CTL1, 8'he0);
      start(5'h01);
      wr(`ACS_OFS_CTL0, 8'h06);
      chk_rd(`ACS_OFS_CTL0, 8'h04);
      res_chk(5'h03, 1'b1);
      // reset in mid-conversion
      start(5'h01);
      rst;
      @(negedge aclk);
      chk(32'(core.power), 32'h0);
      chk_rd(`ACS_OFS_CTL0, 8'h00);
      chk_rd(`ACS_OFS_CTL1, 8'h00);
      chk_rd(`ACS_OFS_STAT, 8'h00);
      give_verdict;
   end
endmodule // test_acs_sequencer
`default_nettype wire
